/* sim/disk_cmd_block_decoder_test.sv */
// Self-checking bench for the command block decoder, random plus corner cases.
// Assumes host_adapter_model on the stream side; bench plays the engine.
`timescale 1ns/100ps
module disk_cmd_block_decoder_test;
  localparam int S3 = 40, S200 = 20, S70 = 10;
  logic        clk, nrst, cmd_valid, cmd_ready, exec_start, exec_done, exec_error;
  logic        write_protect, cartridge_changed, track_only, servo_write, resp_ready;
  logic        pattern_from_buffer, ecc_immediate, restore_retry, step_req, step_pulse;
  logic        resp_valid;
  logic [7:0]  cmd_data, sectors_per_track, cmd_code, xfer_count, interleave;
  logic [7:0]  fill_pattern, resp_data;
  logic [2:0]  unit_num;
  logic [20:0] sector_addr;
  logic [1:0]  retry_limit;
  int          fail_count, num_checks;
  logic [7:0]  ops [29] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A,
    8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h13, 8'hC0, 8'hC2, 8'hE0, 8'hE3, 8'hE4,
    8'hE5, 8'hE6, 8'h02, 8'h09, 8'h11, 8'hC1, 8'hE1, 8'hFF};

  disk_cmd_block_decoder #(.STEP_3MS_CYC(S3), .STEP_200US_CYC(S200), .STEP_70US_CYC(S70)) uut (
    .clk, .nrst, .cmd_valid, .cmd_data, .cmd_ready, .sectors_per_track, .exec_start,
    .exec_done, .exec_error, .write_protect, .cartridge_changed, .cmd_code, .unit_num,
    .sector_addr, .track_only, .xfer_count, .interleave, .servo_write, .fill_pattern,
    .pattern_from_buffer, .ecc_immediate, .retry_limit, .restore_retry, .step_req,
    .step_pulse, .resp_valid, .resp_data, .resp_ready);

  host_adapter_model host (.clk, .cmd_valid, .cmd_data, .cmd_ready, .resp_valid,
    .resp_data, .resp_ready);

  // ------
  // Checking
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic int per(input logic [3:0] k);
    case (k)
      4'h4: return S200;
      4'h5: return S70;
      4'h6: return 3000;
      4'h7: return 1500;
      4'h8: return 1200;
      default: return S3;
    endcase
  endfunction

  task automatic issue(input logic [7:0] op, input logic [2:0] un, input logic [20:0] lsa,
                       input logic [7:0] b4, input logic [7:0] ctl, output bit acc);
    logic [7:0] blk [6];
    bit         ok;
    int         n;
    blk = '{op, {un, lsa[20:16]}, lsa[15:8], lsa[7:0], b4, ctl};
    host.send(blk, ok);
    check(ok, 1);
    check(cmd_ready, 0);
    n = 0;
    while (exec_start !== 1'b1 && resp_valid !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    if (n == 6) begin
      fail_count++;
      summarize();
    end
    acc = (exec_start === 1'b1);
  endtask

  task automatic finish_cmd(input bit acc, input logic [2:0] un);
    logic [7:0] st, cpl;
    bit         ok, err;
    err = !acc;
    if (acc) begin
      @(negedge clk);
      err        = 1'($urandom_range(0, 1));
      exec_error = err;
      exec_done  = 1'b1;
      @(negedge clk);
      exec_done  = 1'b0;
      exec_error = 1'b0;
    end
    host.take($urandom_range(0, 3), st, cpl, ok);
    check(ok, 1);
    if (!ok) summarize();
    check(st, {un, 2'b00, write_protect, err, cartridge_changed});
    check(cpl, 8'h00);
    check(cmd_ready, 1);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------
  // Main sequence
  // ------
  initial begin
    int         idx, hd, sc, heads_per_cylinder, n;
    logic [7:0] op, b4, ctl;
    logic [2:0] un;
    logic [20:0] lsa;
    bit         fmt, xfr, trk, uctl, acc, acc_exp;
    nrst = 1'b0;
    exec_done = 1'b0;
    exec_error = 1'b0;
    write_protect = 1'b0;
    cartridge_changed = 1'b0;
    step_req = 1'b0;
    sectors_per_track = 8'h11;
    fail_count = 0;
    num_checks = 0;
    n = $urandom(85829);
    repeat (5) @(negedge clk);
    check({cmd_ready, resp_valid, exec_start, step_pulse}, 4'h8);
    nrst = 1'b1;
    // every step code, last one ignored
    for (int c = 0; c < 17; c++) begin
      issue(c == 16 ? 8'h00 : 8'h0B, 3'h0, 21'h0, 8'h00, c == 16 ? 8'h08 : 8'(c), acc);
      check(acc, 1);
      @(negedge clk);
      step_req = 1'b1;
      n = 0;
      while (step_pulse !== 1'b1 && n < 4) begin
        @(negedge clk);
        n++;
      end
      check(step_pulse, 1);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (step_pulse !== 1'b1 && n < 4000);
      check(n, per(c == 16 ? 4'h0 : 4'(c)));
      step_req = 1'b0;
      finish_cmd(1'b1, 3'h0);
    end
    for (int i = 0; i < 70; i++) begin
      idx = (i < 29) ? i : $urandom_range(0, 28);
      op = ops[idx];
      fmt = op inside {8'h04, 8'h05, 8'h06, 8'h07, 8'h0E};
      xfr = op inside {8'h08, 8'h0A, 8'hE5, 8'hE6};
      trk = fmt || op == 8'h0B;
      uctl = trk || xfr || op == 8'hE3;
      un = ($urandom_range(0, 3) == 0) ? 3'($urandom_range(2, 7)) : 3'($urandom_range(0, 1));
      sectors_per_track = 8'($urandom_range(17, 40));
      heads_per_cylinder = $urandom_range(1, 8);
      hd = $urandom_range(0, heads_per_cylinder - 1);
      sc = $urandom_range(0, sectors_per_track - 1);
      lsa = 21'((($urandom_range(0, 1023) * heads_per_cylinder + hd) * sectors_per_track) + sc);
      // host keeps interleave and spare bits legal
      b4 = fmt ? 8'($urandom_range(0, sectors_per_track - 1)) : 8'($urandom);
      ctl = 8'($urandom);
      if (uctl) ctl &= 8'h8F | (op == 8'h08 ? 8'h40 : 8'h00) |
                       (fmt && op != 8'h05 ? 8'h30 : 8'h00);
      write_protect = 1'($urandom);
      cartridge_changed = 1'($urandom);
      acc_exp = idx < 23 && !(un > 3'h1 && !(op inside {8'h0F, 8'h10, 8'hE0, 8'hE4}));
      issue(op, un, lsa, b4, ctl, acc);
      check(acc, acc_exp);
      if (acc) begin
        check(cmd_code, op);
        check(unit_num, un);
        check(sector_addr, trk ? lsa - sc : lsa);
        check(track_only, trk);
        if (xfr) check(xfer_count, b4);
        if (fmt) check(interleave, b4);
        check(fill_pattern, 8'h6C);
        if (fmt && op != 8'h05)
          check({servo_write, pattern_from_buffer}, {ctl[4], ctl[5]});
        if (op == 8'h08) check(ecc_immediate, ctl[6]);
        if (uctl) check({retry_limit, restore_retry}, ctl[7] ? 3'h0 : 3'h7);
        if (!uctl)
          check({servo_write, pattern_from_buffer, ecc_immediate, restore_retry}, 4'h0);
      end
      finish_cmd(acc, un);
    end
    summarize();
  end
endmodule // disk_cmd_block_decoder_test

/* sim/host_adapter_model.sv */
// Host adapter model: sends six-byte command blocks, takes status bytes.
// Assumes the decoder's stream ports on the same rising-edge clock.
`timescale 1ns/100ps
module host_adapter_model (
  // Clock
  input  wire logic       clk,
  // Command stream
  output logic            cmd_valid,
  output logic [7:0]      cmd_data,
  input  wire logic       cmd_ready,
  // Status return
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_data,
  output logic            resp_ready
);
  initial begin
    cmd_valid  = 1'b0;
    cmd_data   = 8'hA5;
    resp_ready = 1'b0;
  end

  task automatic send(input logic [7:0] blk [6], output bit ok);
    int n;
    ok = 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_data  = blk[i];
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      ok &= (cmd_ready === 1'b1);
      // Taken here; ready settled since the last edge
      @(posedge clk);
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    // Released bus must not keep the last byte
    cmd_data  = ~cmd_data;
  endtask

  // Slow hosts stall before taking the status
  task automatic take(input int stall, output logic [7:0] st, output logic [7:0] cpl,
                      output bit ok);
    int n;
    ok = 1'b1;
    repeat (stall) @(negedge clk);
    @(negedge clk);
    resp_ready = 1'b1;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (resp_valid !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      ok &= (resp_valid === 1'b1);
      // Byte read while it stands, taken at the next edge
      if (k == 0) st = resp_data;
      else cpl = resp_data;
      @(posedge clk);
      @(negedge clk);
    end
    resp_ready = 1'b0;
  endtask
endmodule // host_adapter_model

/* src/disk_cmd_block_decoder.sv */
// Six-byte command block decoder with status and completion byte return.
// Assumes byte stream, engine handshake and drive flags are logic on clk.
//
// Summary of operation
// - take exactly six bytes before decoding
// - first byte holds class and opcode
// - unit from byte 1 top; 0,1 legal
// - 21-bit sector address from bytes 1-3
// - address names sector or track
// - track commands drop the sector part
// - byte 4 is full transfer count
// - control bits 0-3 set step rate
// - control bit 4 requests servo write
// - bit 5 clear fills 6C, else buffer
// - read bit 6 enables immediate correction
// - bit 7 clear: three retries, then restore
// - unused control byte ignored entirely
// - step codes map to fixed periods
// - recognise class 6 and 7 commands
// - every command ends with status byte
// - status top bits carry unit
// - status bits 4,3 zero, bit 1 error
// - all-zero completion byte follows status
// - status bit 2 shows write protect
// - status bit 0 shows cartridge changed
`timescale 1ns/100ps
module disk_cmd_block_decoder #(
  parameter int STEP_3MS_CYC   = disk_cmd_pkg::STEP_3MS_CYC,
  parameter int STEP_200US_CYC = disk_cmd_pkg::STEP_200US_CYC,
  parameter int STEP_70US_CYC  = disk_cmd_pkg::STEP_70US_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Command byte stream
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_data,
  output logic             cmd_ready,
  // Drive geometry
  input  wire logic [7:0]  sectors_per_track,
  // Execution handshake
  output logic             exec_start,
  input  wire logic        exec_done,
  input  wire logic        exec_error,
  input  wire logic        write_protect,
  input  wire logic        cartridge_changed,
  // Decoded command
  output logic [7:0]       cmd_code,
  output logic [2:0]       unit_num,
  output logic [20:0]      sector_addr,
  output logic             track_only,
  output logic [7:0]       xfer_count,
  output logic [7:0]       interleave,
  output logic             servo_write,
  output logic [7:0]       fill_pattern,
  output logic             pattern_from_buffer,
  output logic             ecc_immediate,
  output logic [1:0]       retry_limit,
  output logic             restore_retry,
  // Stepping
  input  wire logic        step_req,
  output logic             step_pulse,
  // Status return
  output logic             resp_valid,
  output logic [7:0]       resp_data,
  input  wire logic        resp_ready
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_COLLECT,
    S_DECODE,
    S_EXEC,
    S_STATUS,
    S_COMPLETE
  } state_e;

  typedef struct packed {
    state_e          state;
    logic [2:0]      idx;
    logic [5:0][7:0] blk;
    logic [2:0]      unit;
    logic [20:0]     lsa;
    logic            trk;
    logic [7:0]      cnt;
    logic [7:0]      ilv;
    logic [3:0]      step;
    logic            servo;
    logic            pat_buf;
    logic            ecc;
    logic [1:0]      retry;
    logic            restore;
    logic            start;
    logic [7:0]      resp;
  } dec_s;

  dec_s st_reg;
  dec_s st_next;

  // ----------------------------------------
  // Decode terms
  // ----------------------------------------
  logic [7:0]  cmd;
  logic [7:0]  ctl;
  logic [2:0]  unit_in;
  logic [20:0] lsa_raw;
  logic [20:0] lsa_sect;
  logic        ctl_used;
  logic        fmt;
  logic        fmt_pat;
  logic        bad;

  assign cmd = st_reg.blk[0];
  assign ctl_used = disk_cmd_pkg::uses_ctl(cmd);
  assign ctl      = ctl_used ? st_reg.blk[5] : 8'h00;
  assign unit_in = st_reg.blk[1][7:disk_cmd_pkg::UNIT_LSB];
  assign lsa_raw = {st_reg.blk[1][4:0], st_reg.blk[2], st_reg.blk[3]};
  assign fmt     = disk_cmd_pkg::is_format(cmd);
  // Check track format carries no pattern or servo option
  assign fmt_pat = fmt && cmd != disk_cmd_pkg::OP_CHK_FMT;

  // sector offset within track
  // Divider is large but only settles once per command
  assign lsa_sect = (sectors_per_track == 8'h00) ? 21'h000000 :
                    21'(lsa_raw % {13'h0000, sectors_per_track});

  assign bad = !disk_cmd_pkg::is_supported(cmd) ||
               (disk_cmd_pkg::uses_unit(cmd) && unit_in > disk_cmd_pkg::UNIT_MAX);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  function automatic logic [7:0] status_byte(input logic [2:0] u, input logic err);
    // bits 4,3 zero, bit 1 error
    return {u, 2'b00, write_protect, err, cartridge_changed};
  endfunction

  always_comb begin
    st_next       = st_reg;
    st_next.start = 1'b0;
    unique case (st_reg.state)
      S_COLLECT: begin
        if (cmd_valid) begin
          st_next.blk[st_reg.idx] = cmd_data;
          st_next.idx             = st_reg.idx + 3'h1;
          if (st_reg.idx == disk_cmd_pkg::LAST_IDX) begin
            st_next.idx   = 3'h0;
            st_next.state = S_DECODE;
          end
        end
      end
      S_DECODE: begin
        st_next.unit = unit_in;
        st_next.trk  = fmt || cmd == disk_cmd_pkg::OP_SEEK;
        st_next.lsa  = st_next.trk ? lsa_raw - lsa_sect : lsa_raw;
        st_next.cnt  = disk_cmd_pkg::is_xfer(cmd) ? st_reg.blk[4] : 8'h00;
        st_next.ilv  = fmt ? st_reg.blk[4] : 8'h00;
        st_next.step = ctl_used ? ctl[3:0] : disk_cmd_pkg::STEP_DEFAULT;
        st_next.servo   = fmt_pat && ctl[disk_cmd_pkg::CTL_SERVO_BIT];
        st_next.pat_buf = fmt_pat && ctl[disk_cmd_pkg::CTL_PATTERN_BIT];
        st_next.ecc     = cmd == disk_cmd_pkg::OP_READ && ctl[disk_cmd_pkg::CTL_ECC_BIT];
        st_next.restore = ctl_used && !ctl[disk_cmd_pkg::CTL_RETRY_BIT];
        st_next.retry   = st_next.restore ? disk_cmd_pkg::RETRY_COUNT : 2'h0;
        if (bad) begin
          st_next.resp  = status_byte(unit_in, 1'b1);
          st_next.state = S_STATUS;
        end else begin
          st_next.start = 1'b1;
          st_next.state = S_EXEC;
        end
      end
      S_EXEC: begin
        if (exec_done) begin
          st_next.resp  = status_byte(st_reg.unit, exec_error);
          st_next.state = S_STATUS;
        end
      end
      S_STATUS: begin
        if (resp_ready) begin
          st_next.resp  = disk_cmd_pkg::COMPLETION_BYTE;
          st_next.state = S_COMPLETE;
        end
      end
      S_COMPLETE: begin
        if (resp_ready) begin
          st_next.state = S_COLLECT;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cmd_ready           = st_reg.state == S_COLLECT;
  assign exec_start          = st_reg.start;
  assign cmd_code            = cmd;
  assign unit_num            = st_reg.unit;
  assign sector_addr         = st_reg.lsa;
  assign track_only          = st_reg.trk;
  assign xfer_count          = st_reg.cnt;
  assign interleave          = st_reg.ilv;
  assign servo_write         = st_reg.servo;
  assign fill_pattern        = disk_cmd_pkg::FILL_PATTERN;
  assign pattern_from_buffer = st_reg.pat_buf;
  assign ecc_immediate       = st_reg.ecc;
  assign retry_limit         = st_reg.retry;
  assign restore_retry       = st_reg.restore;
  assign resp_valid          = st_reg.state == S_STATUS || st_reg.state == S_COMPLETE;
  assign resp_data           = st_reg.resp;

  // ----------------------------------------
  // Stepping
  // ----------------------------------------
  logic [disk_cmd_pkg::STEP_W-1:0] step_period;

  step_rate_table #(
    .STEP_3MS_CYC   (STEP_3MS_CYC),
    .STEP_200US_CYC (STEP_200US_CYC),
    .STEP_70US_CYC  (STEP_70US_CYC)
  ) u_table (
    .clk    (clk),
    .nrst   (nrst),
    .code   (st_reg.step),
    .period (step_period)
  );

  step_pulse_gen u_steps (
    .clk        (clk),
    .nrst       (nrst),
    .step_req   (step_req),
    .period     (step_period),
    .step_pulse (step_pulse)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  six_bytes_a: assert property (
    st_reg.state == S_COLLECT && cmd_valid && st_reg.idx == disk_cmd_pkg::LAST_IDX
    |=> st_reg.state == S_DECODE ##1 (exec_start || resp_valid))
    else $error("decode did not follow sixth byte");

  unit_field_a: assert property (
    exec_start |-> unit_num == st_reg.blk[1][7:5] &&
                   (unit_num <= 3'h1 || !disk_cmd_pkg::uses_unit(cmd_code)))
    else $error("unit number wrong or illegal");

  lsa_build_a: assert property (
    exec_start && !track_only |-> sector_addr == {st_reg.blk[1][4:0], st_reg.blk[2],
                                                  st_reg.blk[3]})
    else $error("sector address misassembled");

  count_a: assert property (
    exec_start && cmd_code == disk_cmd_pkg::OP_WRITE |-> xfer_count == st_reg.blk[4])
    else $error("block count not taken from byte 4");

  pattern_sel_a: assert property (
    exec_start && cmd_code == disk_cmd_pkg::OP_FMT_TRACK
    |-> pattern_from_buffer == st_reg.blk[5][5] && fill_pattern == 8'h6C)
    else $error("format pattern selection wrong");

  ecc_read_a: assert property (
    exec_start |-> ecc_immediate == (cmd_code == 8'h08 && st_reg.blk[5][6]))
    else $error("immediate correction misdecoded");

  retry_mode_a: assert property (
    exec_start && cmd_code == disk_cmd_pkg::OP_READ
    |-> retry_limit == (st_reg.blk[5][7] ? 2'h0 : 2'h3))
    else $error("retry count wrong");

  reject_a: assert property (
    st_reg.state == S_DECODE && !disk_cmd_pkg::is_supported(cmd)
    |=> resp_valid && resp_data[1] && !exec_start)
    else $error("unsupported command not rejected");

  status_bits_a: assert property (
    st_reg.state == S_EXEC && exec_done
    |=> resp_valid && resp_data[4:3] == 2'b00 && resp_data[1] == $past(exec_error))
    else $error("status byte fields wrong");

  completion_a: assert property (
    st_reg.state == S_STATUS && resp_ready |=> resp_valid && resp_data == 8'h00)
    else $error("completion byte missing");

  ready_back_a: assert property (
    st_reg.state == S_COMPLETE && resp_ready |=> cmd_ready && !resp_valid)
    else $error("bus not released after completion byte");

  status_unit_a: assert property (
    st_reg.state == S_EXEC && exec_done |=> resp_data[7:5] == unit_num)
    else $error("status unit field wrong");

  status_flags_a: assert property (
    st_reg.state == S_EXEC && exec_done
    |=> resp_data[2] == $past(write_protect) && resp_data[0] == $past(cartridge_changed))
    else $error("write protect or cartridge flag wrong");

  servo_fmt_a: assert property (
    exec_start && cmd_code == disk_cmd_pkg::OP_FMT_DRIVE
    |-> servo_write == st_reg.blk[5][disk_cmd_pkg::CTL_SERVO_BIT])
    else $error("servo write request misdecoded");

  track_round_a: assert property (
    exec_start && track_only && sectors_per_track != 8'h00
    |-> sector_addr % 21'(sectors_per_track) == 21'h0)
    else $error("track address not on a track start");

  ctl_ignore_a: assert property (
    exec_start && !disk_cmd_pkg::uses_ctl(cmd_code)
    |-> !servo_write && !pattern_from_buffer && !ecc_immediate && !restore_retry)
    else $error("unused control byte was applied");

  step_code_a: assert property (
    exec_start |-> st_reg.step == (disk_cmd_pkg::uses_ctl(cmd_code) ? st_reg.blk[5][3:0]
                                                                     : 4'h0))
    else $error("step code misdecoded");

endmodule // disk_cmd_block_decoder

/* src/disk_cmd_pkg.sv */
// Constants, field layout and command decode helpers for the command block decoder.
// Assumes one 100 MHz clock shared by every user of this package.
package disk_cmd_pkg;

  // ----------------------------------------
  // Block and clock
  // ----------------------------------------
  localparam int        CMD_BYTES = 6;
  localparam int        CLK_NS    = 10;
  localparam logic [2:0] LAST_IDX = 3'h5;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int         UNIT_LSB        = 5;
  localparam logic [2:0] UNIT_MAX        = 3'h1;
  localparam int         CTL_SERVO_BIT   = 4;
  localparam int         CTL_PATTERN_BIT = 5;
  localparam int         CTL_ECC_BIT     = 6;
  localparam int         CTL_RETRY_BIT   = 7;
  localparam logic [7:0] FILL_PATTERN    = 8'h6C;
  localparam logic [1:0] RETRY_COUNT     = 2'h3;
  localparam logic [7:0] COMPLETION_BYTE = 8'h00;
  localparam logic [3:0] STEP_DEFAULT    = 4'h0;

  // ----------------------------------------
  // Step periods
  // ----------------------------------------
  localparam int STEP_3MS_NS   = 3000000;
  localparam int STEP_200US_NS = 200000;
  localparam int STEP_70US_NS  = 70000;
  localparam int STEP_30US_NS  = 30000;
  localparam int STEP_15US_NS  = 15000;
  localparam int STEP_12US_NS  = 12000;
  localparam int STEP_3MS_CYC   = (STEP_3MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_200US_CYC = (STEP_200US_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_70US_CYC  = (STEP_70US_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_30US_CYC  = (STEP_30US_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_15US_CYC  = (STEP_15US_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_12US_CYC  = (STEP_12US_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_W         = 19;

  // ----------------------------------------
  // Command bytes (class in 7:5, opcode in 4:0)
  // ----------------------------------------
  localparam logic [7:0] OP_FMT_DRIVE = 8'h04;
  localparam logic [7:0] OP_CHK_FMT   = 8'h05;
  localparam logic [7:0] OP_FMT_TRACK = 8'h06;
  localparam logic [7:0] OP_FMT_BAD   = 8'h07;
  localparam logic [7:0] OP_READ      = 8'h08;
  localparam logic [7:0] OP_WRITE     = 8'h0A;
  localparam logic [7:0] OP_SEEK      = 8'h0B;
  localparam logic [7:0] OP_FMT_ALT   = 8'h0E;
  localparam logic [7:0] OP_WR_BUF    = 8'h0F;
  localparam logic [7:0] OP_RD_BUF    = 8'h10;
  localparam logic [7:0] OP_REINIT    = 8'hC2;
  localparam logic [7:0] OP_RAM_DIAG  = 8'hE0;
  localparam logic [7:0] OP_DRV_DIAG  = 8'hE3;
  localparam logic [7:0] OP_CTL_DIAG  = 8'hE4;
  localparam logic [7:0] OP_RD_LONG   = 8'hE5;
  localparam logic [7:0] OP_WR_LONG   = 8'hE6;

  function automatic logic is_format(input logic [7:0] c);
    return c == OP_FMT_DRIVE || c == OP_CHK_FMT || c == OP_FMT_TRACK ||
           c == OP_FMT_BAD || c == OP_FMT_ALT;
  endfunction

  function automatic logic is_xfer(input logic [7:0] c);
    return c == OP_READ || c == OP_WRITE || c == OP_RD_LONG || c == OP_WR_LONG;
  endfunction

  function automatic logic is_supported(input logic [7:0] c);
    logic class0;
    class0 = (c[7:5] == 3'h0) && (c[4:0] <= 5'h10 || c[4:0] == 5'h13) &&
             c[4:0] != 5'h02 && c[4:0] != 5'h09;
    return class0 || c == 8'hC0 || c == OP_REINIT || c == OP_RAM_DIAG ||
           c == OP_DRV_DIAG || c == OP_CTL_DIAG || c == OP_RD_LONG || c == OP_WR_LONG;
  endfunction

  function automatic logic uses_unit(input logic [7:0] c);
    return !(c == OP_WR_BUF || c == OP_RD_BUF || c == OP_RAM_DIAG || c == OP_CTL_DIAG);
  endfunction

  function automatic logic uses_ctl(input logic [7:0] c);
    return is_format(c) || is_xfer(c) || c == OP_SEEK || c == OP_DRV_DIAG;
  endfunction

endpackage

/* src/step_pulse_gen.sv */
// Emits one-cycle step pulses spaced by a period while stepping is requested.
// Assumes the period input is held steady for the whole seek.
`timescale 1ns/100ps
module step_pulse_gen (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            nrst,
  // Control
  input  wire logic                            step_req,
  input  wire logic [disk_cmd_pkg::STEP_W-1:0] period,
  output logic                                 step_pulse
);

  typedef struct packed {
    logic [disk_cmd_pkg::STEP_W-1:0] cnt;
    logic                            pulse;
  } gen_s;

  gen_s st_reg;
  gen_s st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.pulse = 1'b0;
    if (!step_req) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == '0) begin
      st_next.pulse = 1'b1;
      st_next.cnt   = period - disk_cmd_pkg::STEP_W'(1);
    end else begin
      st_next.cnt = st_reg.cnt - disk_cmd_pkg::STEP_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign step_pulse = st_reg.pulse;

endmodule // step_pulse_gen

/* src/step_rate_table.sv */
// Registered lookup from step rate code to step period in clock cycles.
// Assumes the code is stable logic on the same clock.
`timescale 1ns/100ps
module step_rate_table #(
  parameter int STEP_3MS_CYC   = disk_cmd_pkg::STEP_3MS_CYC,
  parameter int STEP_200US_CYC = disk_cmd_pkg::STEP_200US_CYC,
  parameter int STEP_70US_CYC  = disk_cmd_pkg::STEP_70US_CYC
) (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            nrst,
  // Lookup
  input  wire logic [3:0]                      code,
  output logic      [disk_cmd_pkg::STEP_W-1:0] period
);

  typedef struct packed {
    logic [disk_cmd_pkg::STEP_W-1:0] period;
  } tab_s;

  tab_s st_reg;
  tab_s st_next;

  always_comb begin
    st_next = st_reg;
    unique case (code)
      4'h4:    st_next.period = disk_cmd_pkg::STEP_W'(STEP_200US_CYC);
      4'h5:    st_next.period = disk_cmd_pkg::STEP_W'(STEP_70US_CYC);
      4'h6:    st_next.period = disk_cmd_pkg::STEP_W'(disk_cmd_pkg::STEP_30US_CYC);
      4'h7:    st_next.period = disk_cmd_pkg::STEP_W'(disk_cmd_pkg::STEP_15US_CYC);
      4'h8:    st_next.period = disk_cmd_pkg::STEP_W'(disk_cmd_pkg::STEP_12US_CYC);
      // reserved and spare codes step slow
      default: st_next.period = disk_cmd_pkg::STEP_W'(STEP_3MS_CYC);
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign period = st_reg.period;

  step_fast_a: assert property (@(posedge clk) disable iff (!nrst)
    code == 4'h5 |=> period == disk_cmd_pkg::STEP_W'(STEP_70US_CYC))
    else $error("step code 5 gave wrong period");

endmodule // step_rate_table
